//--- rtl/eib_pkg.sv
package eib_pkg;
  // Timing
  localparam int unsigned CLK_HZ     = 125_000_000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STDLY  = 8'h04;
  localparam logic [7:0] OFS_EMIN   = 8'h08;
  localparam logic [7:0] OFS_RMIN   = 8'h0c;
  localparam logic [7:0] OFS_RMAX   = 8'h10;
  localparam logic [7:0] OFS_EMAX   = 8'h14;
  localparam logic [7:0] OFS_HYST   = 8'h18;
  localparam logic [7:0] OFS_PARAM  = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_COUNT  = 8'h24;
  localparam logic [7:0] OFS_RAW    = 8'h28;
  localparam logic [7:0] OFS_PCT    = 8'h2c;
  localparam logic [7:0] OFS_ISTAT  = 8'h30;
  localparam logic [7:0] OFS_IMASK  = 8'h34;

  // Input type codes
  localparam logic [1:0] AB_OFF  = 2'h0;
  localparam logic [1:0] AB_DIG  = 2'h1;
  localparam logic [1:0] AB_ENC  = 2'h2;
  localparam logic [2:0] Z_OFF   = 3'h0;
  localparam logic [2:0] Z_DIG   = 3'h1;
  localparam logic [2:0] Z_FREQ  = 3'h2;
  localparam logic [2:0] Z_PWM   = 3'h3;
  localparam logic [2:0] Z_CNT   = 3'h4;
  localparam logic [2:0] Z_TWIN  = 3'h5;
  localparam logic [2:0] Z_PWIN  = 3'h6;

  // Direction codes
  localparam logic [1:0] DIR_STOP = 2'h0;
  localparam logic [1:0] DIR_NEG  = 2'h1;
  localparam logic [1:0] DIR_POS  = 2'h2;

  // Reset and default values
  localparam logic [31:0] STDLY_DEF = 32'h64;
  localparam logic [31:0] PWM_EMIN  = 32'h1;
  localparam logic [31:0] PWM_RMIN  = 32'h5;
  localparam logic [31:0] PWM_RMAX  = 32'h5f;
  localparam logic [31:0] PWM_EMAX  = 32'h63;
  localparam logic [31:0] PWM_HYST  = 32'h1;
  localparam logic [31:0] DIG_OFF   = 32'h0;
  localparam logic [31:0] DIG_ON    = 32'h1;
  localparam logic [31:0] PCT_FULL  = 32'h64;
  localparam logic [31:0] PARAM_DEF = 32'h3e8;

  // Interrupt bit positions
  localparam int unsigned IRQ_STEP = 0;
  localparam int unsigned IRQ_DIR  = 1;
  localparam int unsigned IRQ_MEAS = 2;
  localparam int unsigned IRQ_FLT  = 3;
  localparam int unsigned IRQ_W    = 4;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic       z_fall;
    logic [2:0] z_type;
    logic [1:0] b_type;
    logic [1:0] a_type;
  } eib_ctrl_s;

  typedef struct packed {
    logic z;
    logic b;
    logic a;
  } eib_pins_s;
endpackage : eib_pkg

//--- rtl/eib_top.sv
`timescale 1ns/1ns
`default_nettype none
module eib_top #(
  parameter int unsigned MS_CYCLES = eib_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Encoder pins
  input  wire eib_pkg::eib_pins_s enc_in,
  // Block outputs
  output logic                  dig_a,
  output logic                  dig_b,
  output logic                  dig_z,
  output logic [1:0]            direction,
  output logic [31:0]           step_count,
  output logic                  z_fault,
  output logic                  z_out_en,
  output logic                  irq
);
  import eib_pkg::*;

  eib_ctrl_s   ctrl_reg;
  logic [31:0] stdly_reg, emin_reg, rmin_reg, rmax_reg, emax_reg;
  logic [31:0] hyst_reg, param_reg;
  logic [IRQ_W-1:0] istat_reg, imask_reg, ev;
  logic [2:0]  sync1_reg, sync2_reg, prev_reg;
  logic [1:0]  dir_reg;
  logic [31:0] cnt_reg, idle_reg, tick_reg;
  logic        ms_tick;
  logic [31:0] per_cnt, hi_cnt, pul_cnt, win_cnt, raw_reg, pct_reg;
  logic        meas_stb, flt_reg, da_reg, db_reg, dz_reg;

  // AXI write and read channel state
  logic        aw_full, w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data, w_mask;
  logic [1:0]  bresp_reg;
  logic        bvalid_reg, wr_go;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        rvalid_reg, rd_go, istat_clr;
  logic [31:0] ctrl_wr, imask_wr;

  assign s_axi_awready = !aw_full && !bvalid_reg;
  assign s_axi_wready  = !w_full && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wr_go = aw_full && w_full && !bvalid_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg;
  assign istat_clr = rd_go && (s_axi_araddr == OFS_ISTAT);
  // Inline merge: a function here would miss changes of w_mask
  assign ctrl_wr  = ({24'h0, ctrl_reg} & ~w_mask) | (w_data & w_mask);
  assign imask_wr = ({28'h0, imask_reg} & ~w_mask) | (w_data & w_mask);

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= OFS_IMASK);
  endfunction : addr_ok

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~w_mask) | (w_data & w_mask);
  endfunction : merge

  // Address and data may arrive in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_mask  <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_mask <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
      end else if (wr_go) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OK;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= addr_ok(aw_addr) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Configuration; a PWM, digital or count Z type write reloads the fixed limits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg  <= '0;
      stdly_reg <= STDLY_DEF;
      emin_reg  <= DIG_OFF;
      rmin_reg  <= DIG_OFF;
      rmax_reg  <= DIG_ON;
      emax_reg  <= DIG_ON;
      hyst_reg  <= DIG_OFF;
      param_reg <= PARAM_DEF;
      imask_reg <= '0;
    end else if (wr_go) begin
      case (aw_addr)
        OFS_CTRL: begin
          ctrl_reg <= eib_ctrl_s'(ctrl_wr[7:0]);
          if (w_mask[0]) begin
            case (w_data[6:4])
              Z_PWM: begin
                emin_reg <= PWM_EMIN;
                rmin_reg <= PWM_RMIN;
                rmax_reg <= PWM_RMAX;
                emax_reg <= PWM_EMAX;
                hyst_reg <= PWM_HYST;
              end
              Z_DIG, Z_CNT: begin
                emin_reg <= DIG_OFF;
                rmin_reg <= DIG_OFF;
                rmax_reg <= DIG_ON;
                emax_reg <= DIG_ON;
                hyst_reg <= DIG_OFF;
              end
              default: ;
            endcase
          end
        end
        OFS_STDLY: stdly_reg <= merge(stdly_reg);
        OFS_EMIN:  emin_reg  <= merge(emin_reg);
        OFS_RMIN:  rmin_reg  <= merge(rmin_reg);
        OFS_RMAX:  rmax_reg  <= merge(rmax_reg);
        OFS_EMAX:  emax_reg  <= merge(emax_reg);
        OFS_HYST:  hyst_reg  <= merge(hyst_reg);
        OFS_PARAM: param_reg <= merge(param_reg);
        OFS_IMASK: imask_reg <= imask_wr[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Read path; an interrupt status read clears the sticky bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OK;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= addr_ok(s_axi_araddr) ? RESP_OK : RESP_ERR;
      case (s_axi_araddr)
        OFS_CTRL:   rdata_reg <= {24'h0, ctrl_reg};
        OFS_STDLY:  rdata_reg <= stdly_reg;
        OFS_EMIN:   rdata_reg <= emin_reg;
        OFS_RMIN:   rdata_reg <= rmin_reg;
        OFS_RMAX:   rdata_reg <= rmax_reg;
        OFS_EMAX:   rdata_reg <= emax_reg;
        OFS_HYST:   rdata_reg <= hyst_reg;
        OFS_PARAM:  rdata_reg <= param_reg;
        OFS_STATUS: rdata_reg <= {25'h0, z_out_en, flt_reg,
                                  dz_reg, db_reg, da_reg, dir_reg};
        OFS_COUNT:  rdata_reg <= cnt_reg;
        OFS_RAW:    rdata_reg <= raw_reg;
        OFS_PCT:    rdata_reg <= pct_reg;
        OFS_ISTAT:  rdata_reg <= {28'h0, istat_reg};
        OFS_IMASK:  rdata_reg <= {28'h0, imask_reg};
        default:    rdata_reg <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Pin synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg  <= 3'h0;
    end else begin
      sync1_reg <= enc_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic a, b, z, a_p, b_p, z_p, enc_mode, step, up, ab_edge, z_edge;
  assign {z, b, a}       = sync2_reg;
  assign {z_p, b_p, a_p} = prev_reg;
  assign enc_mode = (ctrl_reg.a_type == AB_ENC) &&
                    (ctrl_reg.b_type == AB_ENC);
  assign ab_edge = (a ^ a_p) | (b ^ b_p);
  // One input changing is a step; both at once is a glitch and ignored
  assign step = enc_mode && ((a ^ a_p) ^ (b ^ b_p));
  assign up   = a ^ b_p;
  assign z_edge = ctrl_reg.z_fall ? (z_p & ~z) : (z & ~z_p);

  // Millisecond tick
  assign ms_tick = (tick_reg == MS_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!rst_n || ms_tick) begin
      tick_reg <= 32'h0;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  // Quadrature step counter and direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg  <= 32'h0;
      dir_reg  <= DIR_STOP;
      idle_reg <= 32'h0;
    end else begin
      if (ab_edge) begin
        idle_reg <= 32'h0;
      end else if (ms_tick && idle_reg != 32'hffffffff) begin
        idle_reg <= idle_reg + 32'h1;
      end
      if (!enc_mode) begin
        dir_reg <= DIR_STOP;
      end else if (step) begin
        cnt_reg <= up ? cnt_reg + 32'h1 : cnt_reg - 32'h1;
        dir_reg <= up ? DIR_POS : DIR_NEG;
      end else if (idle_reg >= stdly_reg) begin
        dir_reg <= DIR_STOP;
      end
    end
  end

  // Z measurement by mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_cnt  <= 32'h0;
      hi_cnt   <= 32'h0;
      pul_cnt  <= 32'h0;
      win_cnt  <= 32'h0;
      raw_reg  <= 32'h0;
      meas_stb <= 1'b0;
    end else begin
      meas_stb <= 1'b0;
      per_cnt  <= per_cnt + 32'h1;
      hi_cnt   <= hi_cnt + {31'h0, z};
      case (ctrl_reg.z_type)
        Z_DIG: begin
          raw_reg  <= {31'h0, z};
          meas_stb <= z ^ z_p;
        end
        Z_FREQ, Z_PWM: begin
          if (z_edge) begin
            per_cnt  <= 32'h0;
            // Edge cycle itself counts, else duty reads one cycle short
            hi_cnt   <= {31'h0, z};
            meas_stb <= 1'b1;
            if (ctrl_reg.z_type == Z_FREQ) begin
              raw_reg <= CLK_HZ / (per_cnt + 32'h1);
            end else begin
              raw_reg <= 32'((64'(hi_cnt) * PCT_FULL) /
                             64'(per_cnt + 32'h1));
            end
          end
        end
        Z_CNT: begin
          if (z_edge) begin
            meas_stb <= 1'b1;
            raw_reg  <= (raw_reg + 32'h1 >= param_reg) ? 32'h0
                                                       : raw_reg + 32'h1;
          end
        end
        Z_TWIN: begin
          if (ms_tick && win_cnt + 32'h1 >= param_reg) begin
            raw_reg  <= pul_cnt + {31'h0, z_edge};
            pul_cnt  <= 32'h0;
            win_cnt  <= 32'h0;
            meas_stb <= 1'b1;
          end else begin
            pul_cnt <= pul_cnt + {31'h0, z_edge};
            win_cnt <= win_cnt + {31'h0, ms_tick};
          end
        end
        Z_PWIN: begin
          if (z_edge && pul_cnt + 32'h1 >= param_reg) begin
            raw_reg  <= per_cnt + 32'h1;
            per_cnt  <= 32'h0;
            pul_cnt  <= 32'h0;
            meas_stb <= 1'b1;
          end else begin
            pul_cnt <= pul_cnt + {31'h0, z_edge};
          end
        end
        default: raw_reg <= 32'h0;
      endcase
    end
  end

  // Clamp and scale; a zero span reads as full scale
  logic [31:0] clamped, span;
  assign clamped = (raw_reg < rmin_reg) ? rmin_reg :
                   (raw_reg > rmax_reg) ? rmax_reg : raw_reg;
  assign span = rmax_reg - rmin_reg;

  logic flt_set, flt_clr;
  // Limits ordered by software, so the clear band sits inside the range
  assign flt_set = (raw_reg < emin_reg) || (raw_reg > emax_reg);
  assign flt_clr = (raw_reg >= emin_reg + hyst_reg) &&
                   (raw_reg + hyst_reg <= emax_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pct_reg <= 32'h0;
      flt_reg <= 1'b0;
      da_reg  <= 1'b0;
      db_reg  <= 1'b0;
      dz_reg  <= 1'b0;
    end else begin
      pct_reg <= (span == 32'h0) ? PCT_FULL :
                 32'((64'(clamped - rmin_reg) * PCT_FULL) / 64'(span));
      if (ctrl_reg.z_type == Z_OFF) begin
        flt_reg <= 1'b0;
      end else if (flt_set) begin
        flt_reg <= 1'b1;
      end else if (flt_clr) begin
        flt_reg <= 1'b0;
      end
      da_reg <= (ctrl_reg.a_type == AB_DIG) && a;
      db_reg <= (ctrl_reg.b_type == AB_DIG) && b;
      dz_reg <= (ctrl_reg.z_type == Z_DIG) && z;
    end
  end

  // Sticky events; a set in the clearing cycle survives
  always_comb begin
    ev = '0;
    ev[IRQ_STEP] = step;
    ev[IRQ_DIR]  = enc_mode && step &&
                   (dir_reg != (up ? DIR_POS : DIR_NEG));
    ev[IRQ_MEAS] = meas_stb;
    ev[IRQ_FLT]  = flt_set && !flt_reg && ctrl_reg.z_type != Z_OFF;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_reg <= '0;
    end else begin
      istat_reg <= (istat_clr ? '0 : istat_reg) | ev;
    end
  end

  assign irq        = |(istat_reg & imask_reg);
  assign dig_a      = da_reg;
  assign dig_b      = db_reg;
  assign dig_z      = dz_reg;
  assign direction  = dir_reg;
  assign step_count = cnt_reg;
  assign z_fault    = flt_reg;
  assign z_out_en   = (ctrl_reg.z_type != Z_OFF) && !flt_reg;
endmodule : eib_top
`default_nettype wire

//--- verif/eib_checker.sv
`timescale 1ns/1ns
`default_nettype none
module eib_checker
  import eib_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // Register bus
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  // Pins and outputs
  input wire eib_pkg::eib_pins_s enc_in,
  input wire logic [1:0]    direction,
  input wire logic [31:0]   step_count,
  input wire logic          z_fault,
  input wire logic          z_out_en
);
  logic [1:0] ab_prev_reg;
  logic [2:0] quiet_reg;
  // Saturates so a long still spell never wraps back to zero
  always_ff @(posedge clk) begin
    ab_prev_reg <= {enc_in.b, enc_in.a};
    if (!rst_n || {enc_in.b, enc_in.a} != ab_prev_reg) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  ar_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  dir_code_a: assert property (direction != 2'h3)
    else $error("illegal direction code");
  step_quiet_a: assert property (quiet_reg > 3'h4 |-> $stable(step_count))
    else $error("step count moved with pins still");
  step_dir_a: assert property ($changed(step_count) |-> direction != DIR_STOP)
    else $error("step without direction");
  fault_off_a: assert property (z_fault |-> !z_out_en)
    else $error("output allowed during fault");
  pos_c: cover property (direction == DIR_POS);
  neg_c: cover property (direction == DIR_NEG);
  flt_c: cover property ($rose(z_fault));
endmodule : eib_checker
bind eib_top eib_checker chk_u (.clk(clk), .rst_n(rst_n),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .enc_in(enc_in), .direction(direction), .step_count(step_count),
  .z_fault(z_fault), .z_out_en(z_out_en));
`default_nettype wire

//--- verif/eib_enc_model.sv
`timescale 1ns/1ns
`default_nettype none
module eib_enc_model
  import eib_pkg::*;
(
  // Clock
  input wire logic            clk,
  // Pins toward the block
  output var eib_pkg::eib_pins_s pins
);
  initial pins = '0;
  // Three cycles a phase; turn moves only one of A and B at a time
  task automatic put(input logic a, input logic b);
    @(posedge clk);
    pins.a <= a;
    pins.b <= b;
    repeat (2) @(posedge clk);
  endtask : put
  task automatic turn(input logic fwd, input int n);
    for (int i = 0; i < n; i++) begin
      put(fwd, !fwd);
      put(1'b1, 1'b1);
      put(!fwd, fwd);
      put(1'b0, 1'b0);
    end
  endtask : turn
  task automatic set_z(input logic z);
    @(posedge clk);
    pins.z <= z;
    repeat (3) @(posedge clk);
  endtask : set_z
endmodule : eib_enc_model
`default_nettype wire

//--- verif/eib_top_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module eib_top_tb_top;
  import eib_pkg::*;
  typedef struct packed {
    logic [1:0]  resp;
    logic [31:0] mask;
    logic [31:0] data;
  } eib_exp_s;
  localparam int unsigned MS = 10;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        dig_a, dig_b, dig_z, z_fault, z_out_en;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, direction;
  logic [31:0] wdata, rdata, step_count, last, b;
  eib_pins_s   pins;
  eib_exp_s    rq[$], bq[$], e;
  int unsigned rnd, n, m;
  int          mismatches, compares, cycles;
  eib_top #(.MS_CYCLES(MS)) dut_u (.clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enc_in(pins),
    .dig_a(dig_a), .dig_b(dig_b), .dig_z(dig_z), .direction(direction),
    .step_count(step_count), .z_fault(z_fault), .z_out_en(z_out_en),
    .irq(irq));
  eib_enc_model enc_u (.clk(clk), .pins(pins));
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    bq.push_back('{resp: r, mask: 32'h0, data: 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] mk, input logic [1:0] r);
    rq.push_back('{resp: r, mask: mk, data: d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    last = rdata;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  // Answers are judged here, apart from the drivers
  always @(posedge clk) begin
    if (rvalid && rready) begin
      e = rq.pop_front();
      chk("rdata", rdata & e.mask, e.data & e.mask);
      chk("rresp", 32'(rresp), 32'(e.resp));
    end
    if (bvalid && bready) begin
      e = bq.pop_front();
      chk("bresp", 32'(bresp), 32'(e.resp));
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, cycles, mismatches, compares} = '0;
    wstrb = 4'hf;
    rnd = $urandom(49);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL, 32'h0, '1, RESP_OK);
    rd(OFS_STDLY, STDLY_DEF, '1, RESP_OK);
    rd(OFS_PARAM, PARAM_DEF, '1, RESP_OK);
    rd(8'h3c, 32'h0, '1, RESP_ERR);
    wr(8'h3c, 32'h1, RESP_ERR);
    // Seeded byte lanes; only strobed bytes may change
    wr(OFS_PARAM, 32'h0, RESP_OK);
    wstrb <= rnd[3:0];
    wr(OFS_PARAM, '1, RESP_OK);
    wstrb <= 4'hf;
    rd(OFS_PARAM, {{8{rnd[3]}}, {8{rnd[2]}}, {8{rnd[1]}}, {8{rnd[0]}}},
       '1, RESP_OK);
    for (int c = 0; c < 7; c++) begin
      wr(OFS_CTRL, 32'(c) << 4, RESP_OK);
      rd(OFS_CTRL, 32'(c) << 4, 32'hff, RESP_OK);
    end
    wr(OFS_CTRL, 32'(Z_PWM) << 4, RESP_OK);
    rd(OFS_EMIN, PWM_EMIN, '1, RESP_OK);
    rd(OFS_RMIN, PWM_RMIN, '1, RESP_OK);
    rd(OFS_RMAX, PWM_RMAX, '1, RESP_OK);
    rd(OFS_EMAX, PWM_EMAX, '1, RESP_OK);
    rd(OFS_HYST, PWM_HYST, '1, RESP_OK);
    for (int t = 0; t < 2; t++) begin
      wr(OFS_CTRL, 32'(t) * 32'h15, RESP_OK);
      rnd = $urandom;
      enc_u.put(rnd[0], rnd[1]);
      enc_u.set_z(rnd[2]);
      repeat (3) @(posedge clk);
      chk("dig_a", 32'(dig_a), 32'(rnd[0] & t[0]));
      chk("dig_b", 32'(dig_b), 32'(rnd[1] & t[0]));
      chk("dig_z", 32'(dig_z), 32'(rnd[2] & t[0]));
    end
    enc_u.put(1'b0, 1'b0);
    enc_u.set_z(1'b0);
    wr(OFS_CTRL, 32'(AB_ENC) * 5, RESP_OK);
    n = 2 + $urandom % 6;
    enc_u.turn(1'b1, n);
    repeat (5) @(posedge clk);
    // Every single-pin change is a step, four per encoder cycle
    chk("count", step_count, 4 * n);
    chk("dir", 32'(direction), 32'(DIR_POS));
    m = n + 3;
    enc_u.turn(1'b0, m);
    repeat (5) @(posedge clk);
    chk("count", step_count, 4 * (n - m));
    chk("dir", 32'(direction), 32'(DIR_NEG));
    repeat (MS * 97) @(posedge clk);
    chk("dir", 32'(direction), 32'(DIR_NEG));
    repeat (60) @(posedge clk);
    chk("dir", 32'(direction), 32'(DIR_STOP));
    wr(OFS_PARAM, 32'h5, RESP_OK);
    for (int f = 0; f < 2; f++) begin
      wr(OFS_CTRL, (32'(f) << 7) | (32'(Z_CNT) << 4), RESP_OK);
      rd(OFS_EMAX, DIG_ON, '1, RESP_OK);
      rd(OFS_HYST, DIG_OFF, '1, RESP_OK);
      rd(OFS_RAW, 32'h0, 32'h0, RESP_OK);
      b = last;
      enc_u.set_z(1'b1);
      rd(OFS_RAW, (b + 1 - f) % 5, '1, RESP_OK);
      enc_u.set_z(1'b0);
      rd(OFS_RAW, (b + 1) % 5, '1, RESP_OK);
    end
    b = (b + 1) % 5;
    // Counter wraps at five; walk it to two, above the on limit
    repeat ((7 - b) % 5) begin
      enc_u.set_z(1'b1);
      enc_u.set_z(1'b0);
    end
    rd(OFS_RAW, 32'h2, '1, RESP_OK);
    rd(OFS_PCT, PCT_FULL, '1, RESP_OK);
    chk("fault", 32'(z_fault), 32'h1);
    chk("out_en", 32'(z_out_en), 32'h0);
    chk("irq", 32'(irq), 32'h0);
    wr(OFS_IMASK, 32'h1 << IRQ_FLT, RESP_OK);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h1);
    rd(OFS_ISTAT, 32'h8, 32'h8, RESP_OK);
    repeat (2) @(posedge clk);
    chk("irq", 32'(irq), 32'h0);
    wr(OFS_EMAX, 32'ha, RESP_OK);
    enc_u.set_z(1'b1);
    enc_u.set_z(1'b0);
    chk("fault", 32'(z_fault), 32'h0);
    chk("out_en", 32'(z_out_en), 32'h1);
    rd(OFS_PCT, PCT_FULL, '1, RESP_OK);
    // Period of eight cycles, high for four: frequency, then duty
    for (int p = 0; p < 2; p++) begin
      wr(OFS_CTRL, 32'(Z_FREQ + p) << 4, RESP_OK);
      repeat (2) begin
        enc_u.set_z(1'b1);
        enc_u.set_z(1'b0);
      end
      enc_u.set_z(1'b1);
      rd(OFS_RAW, p ? 32'h32 : CLK_HZ / 8, '1, RESP_OK);
      enc_u.set_z(1'b0);
    end
    rd(OFS_PCT, 32'h32, '1, RESP_OK);
    chk("fault", 32'(z_fault), 32'h0);
    close_out();
  end
endmodule : eib_top_tb_top
`default_nettype wire
